// ==== logic/serial_mux_channel_select.sv ====
// Purpose: serial control of an 8-to-1 analog mux with data pass-through
// Assumes: chip select, serial clock and data sampled on sys_clk
// Notes: serial clock edges found by sampling; serial clock <= 5 MHz
//
// Functional notes
// - chip select high: shift upstream data into four stages per clock rise
// - control word is one enable bit then three select bits
// - chip select fall opens all switches, gap at least 125 ns
// - after the gap, close the selected channel within 700 ns
// - channel stays closed until next fall, opens within 300 ns
// - enable 0 keeps all open; enable 1 closes channel n
// - chip select high: forward driver on, reverse driver off
// - shifted bits reach downstream pin after four stages
// - chip select low: forward off, downstream level passed upstream
`timescale 1ns/1ps
module serial_mux_channel_select #(
  parameter int unsigned on_cyc = mux_ctrl_pkg::switch_on_delay_cyc,
  parameter int unsigned gap_cyc = mux_ctrl_pkg::break_gap_cyc
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial control pins
  input wire logic chip_sel,
  input wire logic ser_clk,
  // upstream data pin (three-signal form, oe low drives)
  input wire logic up_data_in,
  output logic up_data_out,
  output logic up_data_oe_n,
  // downstream data pin (three-signal form, oe low drives)
  input wire logic down_data_in,
  output logic down_data_out,
  output logic down_data_oe_n,
  // analog switch controls, bit n closes channel n
  output logic [7:0] switch_close,
  // status
  output logic word_dropped
);

  mux_ctrl_pkg::sw_state_t state_r, state_nxt;
  logic [3:0] shift_r, shift_nxt;
  logic ser_clk_r, cs_r;
  logic [7:0] chan_r, chan_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic up_out_r, up_oe_n_r, dn_out_r, dn_oe_n_r;
  logic up_out_nxt, up_oe_n_nxt, dn_out_nxt, dn_oe_n_nxt;
  // word being applied, held so the buffer slot can be reused at once
  mux_ctrl_pkg::ctrl_word_t buf_word_r, buf_word_nxt;
  logic drop_r, drop_nxt;
  logic clk_rise, cs_fall;
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  mux_ctrl_pkg::ctrl_word_t buf_out_word, cap_word;

  // decode of a captured word into one-hot switch closes
  function automatic logic [7:0] decode_chan(
    input mux_ctrl_pkg::ctrl_word_t w
  );
    logic [7:0] d;
    d = 8'h00;
    if (w.en) begin
      d[w.sel] = 1'b1;
    end
    return d;
  endfunction : decode_chan

  assign clk_rise = ser_clk && !ser_clk_r;
  assign cs_fall = !chip_sel && cs_r;
  // oldest stage is the enable bit
  assign cap_word = mux_ctrl_pkg::ctrl_word_t'(shift_r);

  // the buffer holds a word taken at chip select fall until the
  // sequencer can use it; a word arriving with both slots full is lost and flags word_dropped
  word_buffer #(
    .width(mux_ctrl_pkg::word_bits)
  ) u_word_buffer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(cs_fall),
    .in_ready(buf_in_ready),
    .in_data(cap_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_word)
  );

  // sequencer takes a new word only when idle or on
  assign buf_out_ready = (state_r == mux_ctrl_pkg::st_idle) ||
                         (state_r == mux_ctrl_pkg::st_on);

  // shift register: only moves while chip select is high
  always_comb begin
    shift_nxt = shift_r;
    if (chip_sel && clk_rise) begin
      shift_nxt = {shift_r[2:0], up_data_in};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= mux_ctrl_pkg::word_reset;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // edge detect samples; reset values equal the idle pin levels, so
  // no false serial clock rise or chip select fall follows reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ser_clk_r <= 1'b0;
      cs_r <= 1'b0;
    end else begin
      ser_clk_r <= ser_clk;
      cs_r <= chip_sel;
    end
  end

  // pin direction and data path; the reverse path costs one sys_clk
  // sample, far below one serial clock period
  always_comb begin
    dn_out_nxt = shift_nxt[3]; // after four stages
    dn_oe_n_nxt = !chip_sel; // forward on when high
    up_oe_n_nxt = chip_sel; // reverse driver on when low
    up_out_nxt = down_data_in; // no serial clock delay
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_out_r <= 1'b0;
      up_oe_n_r <= 1'b1;
      dn_out_r <= 1'b0;
      dn_oe_n_r <= 1'b1;
    end else begin
      up_out_r <= up_out_nxt;
      up_oe_n_r <= up_oe_n_nxt;
      dn_out_r <= dn_out_nxt;
      dn_oe_n_r <= dn_oe_n_nxt;
    end
  end

  // switch sequencer: break, settle, on
  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    cnt_nxt = cnt_r;
    drop_nxt = cs_fall && !buf_in_ready;
    case (state_r)
      mux_ctrl_pkg::st_idle, mux_ctrl_pkg::st_on: begin
        if (buf_out_valid) begin
          chan_nxt = 8'h00; // all open at once
          cnt_nxt = 8'(gap_cyc);
          state_nxt = mux_ctrl_pkg::st_break;
        end
      end
      mux_ctrl_pkg::st_break: begin
        if (cnt_r <= 8'h1) begin
          cnt_nxt = 8'(on_cyc - gap_cyc);
          state_nxt = mux_ctrl_pkg::st_settle; // gap kept
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      mux_ctrl_pkg::st_settle: begin
        if (cnt_r <= 8'h1) begin
          chan_nxt = decode_chan(buf_word_r); // close in time
          state_nxt = mux_ctrl_pkg::st_on;
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      default: begin
        state_nxt = mux_ctrl_pkg::st_idle;
      end
    endcase
  end

  // hold the word being applied
  always_comb begin
    buf_word_nxt = buf_word_r;
    if (buf_out_valid && buf_out_ready) begin
      buf_word_nxt = buf_out_word;
    end
  end

  // sequencer registers; all open is the safe state after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= mux_ctrl_pkg::st_idle;
      chan_r <= mux_ctrl_pkg::chan_reset;
      cnt_r <= mux_ctrl_pkg::delay_reset;
      buf_word_r <= '0;
      drop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      cnt_r <= cnt_nxt;
      buf_word_r <= buf_word_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign up_data_out = up_out_r;
  assign up_data_oe_n = up_oe_n_r;
  assign down_data_out = dn_out_r;
  assign down_data_oe_n = dn_oe_n_r;
  assign switch_close = chan_r;
  assign word_dropped = drop_r;

endmodule : serial_mux_channel_select

// ==== logic/mux_ctrl_pkg.sv ====
// Purpose: shared constants and types for the serial mux channel select
// Assumes: sys_clk at 125 MHz (8 ns period)
// Notes: delays are kept in ns, the clock period in ps, cycle counts derived from the clock rate
package mux_ctrl_pkg;

  localparam int unsigned clk_period_ps = 8000;
  localparam int unsigned word_bits = 4;
  localparam int unsigned chan_count = 8;

  // break gap is a least time: round up
  localparam int unsigned break_gap_ns = 125;
  localparam int unsigned break_gap_cyc =
    (break_gap_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  // switch on delay is a longest time: round down
  localparam int unsigned switch_on_delay_ns = 700;
  localparam int unsigned switch_on_delay_cyc =
    (switch_on_delay_ns * 1000) / clk_period_ps;
  // switch off delay is a longest time: round down
  localparam int unsigned switch_off_delay_ns = 300;
  localparam int unsigned switch_off_delay_cyc =
    (switch_off_delay_ns * 1000) / clk_period_ps;

  // field positions inside the shifted word (oldest stage = msb)
  localparam int unsigned enable_pos = 3;
  localparam int unsigned select_bit_high_pos = 2;
  localparam int unsigned select_bit_low_pos = 0;

  localparam logic [3:0] word_reset = 4'h0;
  localparam logic [7:0] chan_reset = 8'h00;
  localparam logic [7:0] delay_reset = 8'h00;

  // captured control word
  typedef struct packed {
    logic en;
    logic [2:0] sel;
  } ctrl_word_t;

  // switch sequencer states, gray along idle-break-settle-on
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_break = 2'b01,
    st_settle = 2'b11,
    st_on = 2'b10
  } sw_state_t;

endpackage : mux_ctrl_pkg

// ==== logic/word_buffer.sv ====
// Purpose: two-entry buffer between the shift register and the sequencer
// Assumes: single clock, valid/ready handshake on both sides
// Notes: full and empty are exact; in_ready drops when both slots hold data
`timescale 1ns/1ps
module word_buffer #(
  parameter int unsigned width = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);

  logic [width-1:0] slot_r [2];
  logic [width-1:0] slot_nxt [2];
  logic [1:0] count_r, count_nxt;
  logic rd_ptr_r, rd_ptr_nxt, wr_ptr_r, wr_ptr_nxt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = slot_r[rd_ptr_r];

  // pointer and slot updates
  always_comb begin
    slot_nxt = slot_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      slot_nxt[wr_ptr_r] = in_data;
      wr_ptr_nxt = ~wr_ptr_r;
    end
    if (pop) begin
      rd_ptr_nxt = ~rd_ptr_r;
    end
    if (push && !pop) begin
      count_nxt = count_r + 2'h1;
    end else if (pop && !push) begin
      count_nxt = count_r - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
      count_r <= 2'h0;
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      count_r <= count_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

endmodule : word_buffer

// ==== tb/mux_sel_chk_asserts.sv ====
// Purpose: port checker for the serial mux select block
// Assumes: one clock, reset low; on and gap counts handed in by bind
// Notes: keeps its own copy of the shift path to predict the word
`timescale 1ns/1ps
module mux_sel_chk #(
  parameter int unsigned on_cyc = 4,
  parameter int unsigned gap_cyc = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial control pins
  input wire logic chip_sel,
  input wire logic ser_clk,
  // data pins
  input wire logic up_data_in,
  input wire logic up_data_out,
  input wire logic up_data_oe_n,
  input wire logic down_data_in,
  input wire logic down_data_out,
  input wire logic down_data_oe_n,
  // switches and status
  input wire logic [7:0] switch_close,
  input wire logic word_dropped
);
  // window is wide enough for one queued word ahead of this one
  localparam int on_lim = 2 * on_cyc + gap_cyc + 12;
  logic [3:0] sh_r;
  logic [1:0] run_r;
  logic [7:0] zero_r;
  logic clk_d_r;
  logic rise;
  logic [7:0] dec;
  assign rise = chip_sel && ser_clk && !clk_d_r;
  assign dec = sh_r[3] ? 8'h01 << sh_r[2:0] : 8'h00;
  // mirror shift path, count edges since reset and open cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 4'h0;
      run_r <= 2'h0;
      zero_r <= 8'h00;
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= ser_clk;
      run_r <= (run_r == 2'h3) ? run_r : run_r + 2'h1;
      zero_r <= (switch_close != 8'h00) ? 8'h00 :
        (zero_r == 8'hff) ? zero_r : zero_r + 8'h01;
      if (rise) sh_r <= {sh_r[2:0], up_data_in};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_shift_forward: assert property (rise |=>
    down_data_out == sh_r[3]) else $error("forward bit wrong");
  a_fall_opens: assert property ($fell(chip_sel) |-> ##2
    switch_close == 8'h00) else $error("switches not opened");
  a_chan_close: assert property ($fell(chip_sel) |->
    ##[3:on_lim] switch_close == dec) else $error("channel not closed");
  a_gap_min: assert property ($rose(switch_close != 8'h00) |->
    zero_r >= gap_cyc) else $error("break gap too short");
  a_one_hot: assert property ($onehot0(switch_close))
    else $error("more than one channel closed");
  a_hold_shift: assert property (run_r[1] && chip_sel &&
    $past(chip_sel) |-> $stable(switch_close)) else $error("moved early");
  a_fwd_drive: assert property (run_r[1] && chip_sel &&
    $past(chip_sel) && $past(chip_sel, 2) |-> !down_data_oe_n &&
    up_data_oe_n) else $error("forward drivers wrong");
  a_rev_drive: assert property (run_r[1] && !chip_sel &&
    !$past(chip_sel) && !$past(chip_sel, 2) |-> down_data_oe_n &&
    !up_data_oe_n && up_data_out == $past(down_data_in))
    else $error("reverse path wrong");
  c_fall: cover property ($fell(chip_sel));
  c_shift: cover property (rise);
  c_drop: cover property (word_dropped);
endmodule : mux_sel_chk

bind serial_mux_channel_select mux_sel_chk #(.on_cyc(on_cyc),
  .gap_cyc(gap_cyc)) chk (.sys_clk(sys_clk), .rstn(rstn),
  .chip_sel(chip_sel), .ser_clk(ser_clk), .up_data_in(up_data_in),
  .up_data_out(up_data_out), .up_data_oe_n(up_data_oe_n),
  .down_data_in(down_data_in), .down_data_out(down_data_out),
  .down_data_oe_n(down_data_oe_n), .switch_close(switch_close),
  .word_dropped(word_dropped));

// ==== tb/down_dev.sv ====
// Purpose: model of the next device on the downstream data pin
// Assumes: shares chip select and serial clock with the block
// Notes: released line shows a toggling level, never the last bit
`timescale 1ns/1ps
module down_dev (
  // clock
  input wire logic sys_clk,
  // shared control pins
  input wire logic chip_sel,
  input wire logic ser_clk,
  // downstream wire
  input wire logic line_in,
  input wire logic reply,
  output logic line_out,
  output logic [3:0] word_r
);
  logic clk_d_r;
  logic tog_r = 1'b0;
  // shifts in what the block passes on, as a chained mux would
  always_ff @(posedge sys_clk) begin
    clk_d_r <= ser_clk;
    tog_r <= ~tog_r;
    if (chip_sel && ser_clk && !clk_d_r) word_r <= {word_r[2:0], line_in};
  end
  // answers only while chip select is low
  assign line_out = chip_sel ? tog_r : reply;
endmodule : down_dev

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the serial mux select block
// Assumes: gap and on counts cut to 2 and 4 cycles
// Notes: host side driven here, far side by down_dev
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic chip_sel = 1'b0;
  logic ser_clk = 1'b0;
  logic host_bit = 1'b0;
  logic reply = 1'b0;
  logic up_data_out, up_data_oe_n, down_data_out, down_data_oe_n;
  logic word_dropped, line_out;
  logic [7:0] switch_close;
  logic [7:0] exp_sw = 8'h00;
  logic [3:0] far_word;
  int n_errors = 0;
  int checks = 0;
  int drops = 0;
  wire up_data_in = up_data_oe_n ? host_bit : up_data_out;
  wire down_data_in = down_data_oe_n ? line_out : down_data_out;
  serial_mux_channel_select #(.on_cyc(4), .gap_cyc(2)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .chip_sel(chip_sel),
    .ser_clk(ser_clk), .up_data_in(up_data_in), .up_data_out(up_data_out),
    .up_data_oe_n(up_data_oe_n), .down_data_in(down_data_in),
    .down_data_out(down_data_out), .down_data_oe_n(down_data_oe_n),
    .switch_close(switch_close), .word_dropped(word_dropped));
  down_dev far (.sys_clk(sys_clk), .chip_sel(chip_sel), .ser_clk(ser_clk),
    .line_in(down_data_in), .reply(reply), .line_out(line_out),
    .word_r(far_word));
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (word_dropped === 1'b1) drops++;
  // move to 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // enable first, 13 system cycles per phase keeps the clock under 5 MHz
  task automatic send(input logic [3:0] w);
    for (int i = 3; i >= 0; i--) begin
      host_bit = w[i];
      tick(13);
      ser_clk = 1'b1;
      tick(13);
      ser_clk = 1'b0;
    end
  endtask : send
  task automatic stop_test;
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    tick(16);
    rstn = 1'b1;
    tick(2);
    // every word code, then apply and look back through the chain
    for (int w = 0; w < 16; w++) begin
      chip_sel = 1'b1;
      send(w[3:0]);
      check(switch_close, exp_sw);
      check({down_data_oe_n, up_data_oe_n}, 8'h01);
      chip_sel = 1'b0;
      exp_sw = w[3] ? 8'h01 << w[2:0] : 8'h00;
      tick(3);
      check(switch_close, 8'h00);
      reply = ~w[0];
      tick(16);
      check(switch_close, exp_sw);
      check({up_data_oe_n, up_data_out}, {7'h0, ~w[0]});
    end
    // two words in one frame: first lands in the far device
    chip_sel = 1'b1;
    send(4'ha);
    send(4'h3);
    check({4'h0, far_word}, 8'h0a);
    chip_sel = 1'b0;
    tick(20);
    check(switch_close, 8'h00);
    // falls faster than words drain, so the buffer overflows
    for (int k = 0; k < 5; k++) begin
      chip_sel = 1'b1;
      tick(1);
      chip_sel = 1'b0;
      tick(1);
    end
    tick(60);
    check({7'h0, drops > 0}, 8'h01);
    stop_test();
  end
endmodule : tb
